/* verilog/frame_sync_cfg.svh */
/*
 * constants of the frame and superframe sync block: register offsets,
 * control register width, reset values and bit-clock timing counts.
 * assumes a link clock of 20.48 MHz (48 ns) driving the bit-clock divider.
 */
`ifndef FRAME_SYNC_CFG_SVH
`define FRAME_SYNC_CFG_SVH

`define FS_ADR_CTRL    8'h00
`define FS_ADR_STAT    8'h04
`define FS_ADR_DTX     8'h08
`define FS_ADR_DRX     8'h0c
`define FS_ADR_ADJ     8'h10
`define FS_CTRL_RST    6'h00
`define FS_CTRL_W      6

`define FS_LINE_NS     48
`define FS_FAST_KHZ    2048
`define FS_SLOW_KHZ    512
`define FS_LINE_KHZ    20480
`define FS_HALF_FAST   (`FS_LINE_KHZ / `FS_FAST_KHZ / 2)
`define FS_HALF_SLOW   (`FS_LINE_KHZ / `FS_SLOW_KHZ / 2)
`define FS_PULSES_FAST 256
`define FS_PULSES_SLOW 64
`define FS_ADJ_FAST    249
`define FS_ADJ_SLOW    59
`define FS_SF_FRAMES   96
`define FS_WIDTH_NORM  2
`define FS_WIDTH_SF    1
`define FS_ADJ_FRAMES  2

`endif

/* verilog/frame_sync_pkg.sv */
/*
 * types of the frame and superframe sync block.
 * assumes frame_sync_cfg.svh for all numeric constants.
 */
package frame_sync_pkg;
	typedef struct packed {
		logic adj_up;   // lengthen the high phase
		logic marks_out; // device drives superframe markers
		logic long_fr;  // long frame mode on the alternate port
		logic nt;       // network termination mode
		logic master;   // device drives bit clock and composite sync
		logic spare;
	} ctrl_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;
	typedef enum logic [1:0] {MK_IDLE, MK_ARM, MK_HIGH} mark_st_t;
endpackage

/* verilog/frame_superframe_sync.sv */
/*
 * frame and superframe sync for the composite-sync port, the alternate
 * serial port markers and the d-channel port, with a wishbone slave.
 * assumes line_clk is the 20.48 MHz line clock and that pins from the
 * far side are asynchronous to both clocks.
 */
`timescale 1ns/1ps
`include "frame_sync_cfg.svh"
module frame_superframe_sync (
	input  wire logic                   sys_clk,     // 50 MHz register clock
	input  wire logic                   arst_n,      // async reset, low
	input  wire logic                   line_clk,    // link clock, 20.48 MHz
	input  wire frame_sync_pkg::wb_req_t wb_req,     // wishbone request
	output logic [31:0]                 wb_dat_o,    // wishbone read data
	output logic                        wb_ack_o,    // wishbone ack
	input  wire logic                   clock_rate_select, // 1: 2.048 MHz
	input  wire logic                   bclk_in,     // bit clock pin in
	output logic                        bclk_out,    // bit clock pin out
	output logic                        bclk_oe,     // bit clock drive
	input  wire logic                   fsc_in,      // composite sync in
	output logic                        fsc_out,     // composite sync out
	output logic                        fsc_oe,      // composite sync drive
	input  wire logic                   tx_frame_sync, // transmit sync
	input  wire logic                   rx_frame_sync, // receive sync
	input  wire logic                   tx_mark_in,  // tx marker pin in
	output logic                        tx_mark_out, // tx marker pin out
	output logic                        tx_mark_oe,  // tx marker drive
	output logic                        rx_superframe_marker, // rx marker
	output logic                        dchan_port_clock, // d-channel clock
	output logic                        dchan_serial_out, // d-channel out
	input  wire logic                   dchan_serial_in  // d-channel in
);
	// sys domain
	frame_sync_pkg::ctrl_t ctrl;
	logic [7:0]  dtx, drx, sf_cnt;
	logic        adj_tog, dtx_tog;
	logic [2:0]  rxt_s, sft_s;
	logic [1:0]  busy_s;
	wire         wb_hit = wb_req.cyc & wb_req.stb & ~wb_ack_o;
	wire         wb_wr  = wb_hit & wb_req.we & wb_req.sel[0];
	wire [31:0]  rd_val =
		(wb_req.adr == `FS_ADR_CTRL) ? {26'h0, ctrl} :
		(wb_req.adr == `FS_ADR_STAT) ? {23'h0, busy_s[1], sf_cnt} :
		(wb_req.adr == `FS_ADR_DTX)  ? {24'h0, dtx} :
		(wb_req.adr == `FS_ADR_DRX)  ? {24'h0, drx} : 32'h0;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl     <= `FS_CTRL_RST;
			dtx      <= 8'h00;
			adj_tog  <= 1'b0;
			dtx_tog  <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= wb_hit ? rd_val : 32'h0;
			if (wb_wr && wb_req.adr == `FS_ADR_CTRL)
				ctrl <= wb_req.dat[`FS_CTRL_W-1:0];
			if (wb_wr && wb_req.adr == `FS_ADR_DTX) begin
				dtx     <= wb_req.dat[7:0];
				dtx_tog <= ~dtx_tog;
			end
			if (wb_wr && wb_req.adr == `FS_ADR_ADJ)
				adj_tog <= ~adj_tog;
		end
	end

	// link events come over as toggles; the hold byte is stable for 8 bits
	logic [7:0] rx_hold;
	logic       rx_tog, sf_tog, busy;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxt_s  <= 3'h0;
			sft_s  <= 3'h0;
			busy_s <= 2'h0;
			drx    <= 8'h00;
			sf_cnt <= 8'h00;
		end else begin
			rxt_s  <= {rxt_s[1:0], rx_tog};
			sft_s  <= {sft_s[1:0], sf_tog};
			busy_s <= {busy_s[0], busy};
			if (rxt_s[2] != rxt_s[1])
				drx <= rx_hold;
			if (sft_s[2] != sft_s[1])
				sf_cnt <= sf_cnt + 8'h01;
		end
	end

	// link domain reset release
	logic [1:0] lrst_s;
	wire        lrst_n = lrst_s[1];
	always_ff @(posedge line_clk or negedge arst_n) begin
		if (!arst_n)
			lrst_s <= 2'h0;
		else
			lrst_s <= {lrst_s[0], 1'b1};
	end

	// two-flop synchronisers; stage 3 feeds edge detection only
	frame_sync_pkg::ctrl_t c1, cl;
	logic [10:0] p1, p2;
	logic [4:0]  p3;
	logic [1:0]  at1, at2;
	wire         rate1 = p2[0];
	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			c1  <= `FS_CTRL_RST;
			cl  <= `FS_CTRL_RST;
			p1  <= 11'h0;
			p2  <= 11'h0;
			p3  <= 5'h0;
			at1 <= 2'h0;
			at2 <= 2'h0;
		end else begin
			c1  <= ctrl;
			cl  <= c1;
			p1  <= {dtx_tog, adj_tog, dchan_serial_in, tx_mark_in,
				rx_frame_sync, tx_frame_sync, fsc_in, bclk_in, 2'b00,
				clock_rate_select};
			p2  <= p1;
			p3  <= p2[7:3];
			at1 <= p2[10:9];
			at2 <= at1;
		end
	end
	wire       s_bclk = p2[3];
	wire       s_fsc  = p2[4];
	wire [1:0] s_fs   = p2[6:5];
	wire       s_mk   = p2[7];
	wire       s_din  = p2[8];
	wire       adj_ev = at1[0] ^ at2[0];
	wire       dtx_ev = at1[1] ^ at2[1];

	// bit clock generator and pulse counter
	logic [4:0] dv;
	logic [7:0] pidx;
	logic [6:0] comp_fr;
	logic [1:0] adj_pend;
	logic [1:0] fsc_w;
	logic       hi, sf_cur;
	wire [4:0]  half    = rate1 ? 5'(`FS_HALF_FAST) : 5'(`FS_HALF_SLOW);
	wire [7:0]  last    = rate1 ? 8'(`FS_PULSES_FAST - 1) : 8'(`FS_PULSES_SLOW - 1);
	wire [7:0]  adj_pos = rate1 ? 8'(`FS_ADJ_FAST) : 8'(`FS_ADJ_SLOW);
	wire        adj_now = cl.nt & (adj_pend != 2'h0) & (pidx == adj_pos);
	wire [4:0]  hi_len  = !adj_now ? half : cl.adj_up ? half + 5'h1 : half - 5'h1;
	wire        wrap    = dv == (hi ? hi_len : half) - 5'h1;
	wire        g_rise  = ~hi & wrap;
	wire        s_rise  = s_bclk & ~p3[0];
	wire        s_fall  = ~s_bclk & p3[0];
	wire        b_rise  = cl.master ? g_rise : s_rise;
	wire        b_fall  = cl.master ? (hi & wrap) : s_fall;
	wire        bsrc    = cl.master ? hi : s_bclk;
	wire [7:0]  next_p  = (pidx == last) ? 8'h00 : pidx + 8'h01;
	wire [6:0]  next_fr = (comp_fr == 7'(`FS_SF_FRAMES - 1)) ? 7'h0 : comp_fr + 7'h1;

	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			dv  <= 5'h0;
			hi  <= 1'b0;
			bclk_out <= 1'b0;
			bclk_oe  <= 1'b0;
		end else begin
			dv  <= (!cl.master || wrap) ? 5'h0 : dv + 5'h1;
			hi  <= cl.master & (wrap ? ~hi : hi);
			bclk_out <= cl.master & (wrap ? ~hi : hi);
			bclk_oe  <= cl.master;
		end
	end

	// composite sync: drive in master, decode width in slave
	logic fsc_smp;
	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			pidx     <= 8'h00;
			comp_fr  <= 7'h0;
			sf_cur   <= 1'b0;
			fsc_out  <= 1'b0;
			fsc_oe   <= 1'b0;
			fsc_w    <= 2'h0;
			fsc_smp  <= 1'b0;
			adj_pend <= 2'h0;
			sf_tog   <= 1'b0;
		end else begin
			fsc_oe <= cl.master;
			if (adj_ev && cl.nt && cl.master)
				adj_pend <= 2'(`FS_ADJ_FRAMES);
			else if (b_rise && next_p == 8'h00 && adj_pend != 2'h0)
				adj_pend <= adj_pend - 2'h1;
			if (cl.master && b_rise) begin
				pidx <= next_p;
				if (next_p == 8'h00) begin
					fsc_out <= 1'b1;
					comp_fr <= next_fr;
					sf_cur  <= next_fr == 7'h0;
					if (next_fr == 7'h0)
						sf_tog <= ~sf_tog;
				end else if (next_p == (sf_cur ? 8'(`FS_WIDTH_SF) : 8'(`FS_WIDTH_NORM)))
					fsc_out <= 1'b0;
			end else if (!cl.master) begin
				fsc_out <= 1'b0;
				if (b_rise)
					pidx <= next_p;
				if (b_fall) begin
					fsc_smp <= s_fsc;
					if (s_fsc && !fsc_smp) begin
						pidx    <= 8'h00;
						comp_fr <= next_fr;
						fsc_w   <= 2'h1;
					end else if (s_fsc && fsc_w != 2'h3)
						fsc_w <= fsc_w + 2'h1;
					if (!s_fsc && fsc_smp && fsc_w == 2'(`FS_WIDTH_SF)) begin
						comp_fr <= 7'h0;
						sf_tog  <= ~sf_tog;
					end
				end
			end
		end
	end
	assign busy = adj_pend != 2'h0;

	// alternate port: per-sync marker counters, index 0 tx, 1 rx
	frame_sync_pkg::mark_st_t mst [2];
	logic [6:0] fr96 [2];
	logic [1:0] fs_smp, first, mk;
	logic       mk_rises;
	wire  [1:0] lrise = s_fs & ~p3[3:2];
	wire  [1:0] sass  = {2{b_fall}} & s_fs & ~fs_smp;
	wire  [1:0] ev    = cl.long_fr ? lrise : sass;
	wire        tx_mk_seen = ~cl.marks_out & ev[0] & s_mk;

	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			fs_smp <= 2'h0;
			first  <= 2'h0;
			mk     <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				fr96[i] <= 7'h0;
				mst[i]  <= frame_sync_pkg::MK_IDLE;
			end
		end else begin
			if (b_fall)
				fs_smp <= s_fs;
			for (int i = 0; i < 2; i++) begin
				if (ev[i]) begin
					fr96[i]  <= (i == 0 && tx_mk_seen) ? 7'h0 :
						(fr96[i] == 7'(`FS_SF_FRAMES - 1)) ? 7'h0 : fr96[i] + 7'h1;
					first[i] <= (i == 0 && tx_mk_seen) ||
						fr96[i] == 7'(`FS_SF_FRAMES - 1);
				end
				if (cl.long_fr) begin
					mst[i] <= frame_sync_pkg::MK_IDLE;
					mk[i]  <= cl.marks_out & s_fs[i] & (ev[i] ?
						fr96[i] == 7'(`FS_SF_FRAMES - 1) : first[i]);
				end else begin
					unique case (mst[i])
						frame_sync_pkg::MK_IDLE: begin
							mk[i] <= 1'b0;
							if (ev[i] && cl.marks_out &&
								fr96[i] == 7'(`FS_SF_FRAMES - 1))
								mst[i] <= frame_sync_pkg::MK_ARM;
						end
						frame_sync_pkg::MK_ARM: if (b_rise) begin
							mk[i]  <= 1'b1;
							mst[i] <= frame_sync_pkg::MK_HIGH;
						end
						frame_sync_pkg::MK_HIGH: if (b_rise) begin
							mk[i]  <= 1'b0;
							mst[i] <= frame_sync_pkg::MK_IDLE;
						end
					endcase
				end
			end
		end
	end
	assign tx_mark_out = mk[0];
	assign rx_superframe_marker = mk[1];
	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n)
			tx_mark_oe <= 1'b0;
		else
			tx_mark_oe <= cl.marks_out;
	end

	// d-channel port: clock follows the bit clock one link cycle later; in slave it follows the synchronised bit clock pin
	logic [7:0] tx_byte, tx_sh, rx_sh;
	logic [2:0] dbit;
	wire        d_rise = bsrc & ~dchan_port_clock;
	wire        d_fall = ~bsrc & dchan_port_clock;
	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			dchan_port_clock <= 1'b0;
			dchan_serial_out <= 1'b0;
			tx_byte <= 8'h00;
			tx_sh   <= 8'h00;
			rx_sh   <= 8'h00;
			rx_hold <= 8'h00;
			rx_tog  <= 1'b0;
			dbit    <= 3'h0;
		end else begin
			dchan_port_clock <= bsrc;
			if (dtx_ev)
				tx_byte <= dtx;
			if (d_rise) begin
				dchan_serial_out <= (dbit == 3'h0) ? tx_byte[7] : tx_sh[7];
				tx_sh <= (dbit == 3'h0) ? {tx_byte[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
			end
			if (d_fall) begin
				rx_sh <= {rx_sh[6:0], s_din};
				dbit  <= dbit + 3'h1;
				if (dbit == 3'h7) begin
					rx_hold <= {rx_sh[6:0], s_din};
					rx_tog  <= ~rx_tog;
				end
			end
		end
	end

	// checking helpers: rises seen while a pulse is high, and link cycles of the bit clock high phase
	logic [1:0] fsc_cnt;
	logic [4:0] hcnt;
	always_ff @(posedge line_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			fsc_cnt  <= 2'h0;
			hcnt     <= 5'h0;
			mk_rises <= 1'b0;
		end else begin
			fsc_cnt  <= !fsc_out ? 2'h0 : (b_rise ? fsc_cnt + 2'h1 : fsc_cnt);
			hcnt     <= hi ? hcnt + 5'h1 : 5'h0;
			mk_rises <= !mk[1] ? 1'b0 : (b_rise | mk_rises);
		end
	end

	property p_norm_width;
		@(posedge line_clk) disable iff (!lrst_n)
		cl.master && $fell(fsc_out) && !sf_cur |-> fsc_cnt == 2'(`FS_WIDTH_NORM);
	endproperty
	a_norm_width: assert property (p_norm_width) else $error("sync not two wide");
	property p_sf_width;
		@(posedge line_clk) disable iff (!lrst_n)
		cl.master && $fell(fsc_out) && sf_cur |-> fsc_cnt == 2'(`FS_WIDTH_SF) && comp_fr == 7'h0;
	endproperty
	a_sf_width: assert property (p_sf_width) else $error("superframe sync not one wide");
	property p_zero;
		@(posedge line_clk) disable iff (!lrst_n)
		cl.master && $rose(fsc_out) |-> pidx == 8'h00 && hi;
	endproperty
	a_zero: assert property (p_zero) else $error("sync not on pulse zero");
	property p_adj_pos;
		@(posedge line_clk) disable iff (!lrst_n)
		adj_now |-> pidx == (rate1 ? 8'd249 : 8'd59);
	endproperty
	a_adj_pos: assert property (p_adj_pos) else $error("adjust on wrong pulse");
	property p_hi_len;
		@(posedge line_clk) disable iff (!lrst_n)
		cl.master && hi && wrap |-> hcnt + 5'h1 == (!adj_now ? half :
			cl.adj_up ? half + 5'h1 : half - 5'h1);
	endproperty
	a_hi_len: assert property (p_hi_len) else $error("high phase length wrong");
	property p_fr_range;
		@(posedge line_clk) disable iff (!lrst_n)
		fr96[0] < 7'd96 && fr96[1] < 7'd96 && comp_fr < 7'd96;
	endproperty
	a_fr_range: assert property (p_fr_range) else $error("frame counter out of range");
	property p_short_mk;
		@(posedge line_clk) disable iff (!lrst_n)
		!cl.long_fr && $fell(mk[1]) |-> mk_rises;
	endproperty
	a_short_mk: assert property (p_short_mk) else $error("marker not one pulse");
	property p_long_mk;
		@(posedge line_clk) disable iff (!lrst_n)
		cl.long_fr && mk[0] |-> $past(s_fs[0]);
	endproperty
	a_long_mk: assert property (p_long_mk) else $error("marker not with sync");
	sequence s_dclk_rise;
		$rose(dchan_port_clock);
	endsequence
	property p_dout_launch;
		@(posedge line_clk) disable iff (!lrst_n)
		$changed(dchan_serial_out) |-> s_dclk_rise;
	endproperty
	a_dout_launch: assert property (p_dout_launch) else $error("dchan out off edge");
endmodule

/* bench/far_side_model.sv */
/* far side of the serial ports: bit clock, syncs, tx marker, d-channel data.
 * assumes the bench resolves shared pins and feeds back the live bit clock. */
`timescale 1ns/1ps
module far_side_model (
	input  wire logic       line_clk, // link clock
	input  wire logic       bclk,     // bit clock on the pin
	input  wire logic       dch_clk,  // d-channel clock from the block
	input  wire logic [1:0] sync_w,   // frame sync width in bit clocks
	input  wire logic [7:0] dch_byte, // byte sent over and over
	output logic            bclk_own, // bit clock for slave mode
	output logic            composite_frame_sync,      // composite sync
	output logic            fsync,    // tx and rx frame sync
	output logic            mark,     // tx superframe marker
	output logic            dch_in    // d-channel data
);
	// short frames keep a superframe inside a short run
	localparam int FRAME = 16;
	int ph = 0;
	int pulse = 0;
	int frame = 0;
	int bitn = 0;
	initial bclk_own = 1'b0;
	initial dch_in = 1'b0;
	always @(posedge line_clk) begin
		ph <= (ph + 1) % 4;
		if (ph == 3)
			bclk_own <= ~bclk_own;
	end
	always @(posedge bclk) begin
		pulse <= (pulse + 1) % FRAME;
		if (pulse == FRAME - 1)
			frame <= (frame + 1) % 96;
	end
	assign fsync = pulse < sync_w;
	assign composite_frame_sync = pulse < ((frame == 0) ? 1 : 2);
	assign mark = (frame == 0) && fsync;
	always @(posedge dch_clk) begin
		dch_in <= dch_byte[7 - bitn];
		bitn <= (bitn + 1) % 8;
	end
endmodule

/* bench/frame_superframe_sync_bench.sv */
/* self-checking bench: registers, master bit clock and sync, slave markers.
 * assumes far_side_model on the serial side and the block's config header. */
`timescale 1ns/1ps
`include "frame_sync_cfg.svh"
module frame_superframe_sync_bench;
	localparam int BIT_NS = 96;
	logic                    sys_clk = 1'b0;
	logic                    line_clk = 1'b0;
	logic                    arst_n = 1'b0;
	frame_sync_pkg::wb_req_t wb_req = '0;
	logic                    clock_rate_select = 1'b0;
	logic [1:0]              sync_w = 2'd1;
	logic [7:0]              dbyte;
	logic [31:0]             r;
	logic [31:0]             wb_dat_o;
	logic                    wb_ack_o, bclk_out, bclk_oe, fsc_out, fsc_oe, tx_mark_out;
	logic                    tx_mark_oe, rx_superframe_marker, dchan_port_clock;
	logic                    dchan_serial_out, bclk_own, fsc_far, fsync, mark_far, dch_in;
	logic                    meas = 1'b0, mmeas = 1'b0, long_mode = 1'b0;
	logic [4:0]              h = '0;
	logic                    dchk = 1'b0;
	logic [7:0]              dsh = '0;
	int                      dn = 0;
	int                      num_errors = 0, tests_run = 0, cycles = 0, ones = 0;
	int                      seed = 32'hdfdd055e, fcount = 0, mk_n[2] = '{0, 0}, mk_last[2];
	int                      half, npulse, want, dir, pidx, hc, fw, odd;
	time                     t_fs, t_m[2];
	logic [31:0]             exp_q[$];
	wire logic bclk_pin = bclk_oe ? bclk_out : bclk_own;
	wire logic fsc_pin = fsc_oe ? fsc_out : fsc_far;
	wire logic mark_pin = tx_mark_oe ? tx_mark_out : mark_far;

	initial forever #10 sys_clk = ~sys_clk;
	initial begin
		#3;
		forever #6 line_clk = ~line_clk;
	end

	frame_superframe_sync dut (
		.sys_clk, .arst_n, .line_clk, .wb_req, .wb_dat_o, .wb_ack_o, .clock_rate_select,
		.bclk_in(bclk_pin), .bclk_out, .bclk_oe, .fsc_in(fsc_pin), .fsc_out, .fsc_oe,
		.tx_frame_sync(fsync), .rx_frame_sync(fsync), .tx_mark_in(mark_pin),
		.tx_mark_out, .tx_mark_oe, .rx_superframe_marker, .dchan_port_clock,
		.dchan_serial_out, .dchan_serial_in(dch_in)
	);
	far_side_model far (
		.line_clk, .bclk(bclk_pin), .dch_clk(dchan_port_clock), .sync_w,
		.dch_byte(dbyte), .bclk_own, .composite_frame_sync(fsc_far), .fsync, .mark(mark_far), .dch_in
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// request held until ack is sampled high, then released
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge sys_clk);
		wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			$display("BAD %0t no ack", $time);
		end
		wb_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0)
			check(wb_dat_o, exp_q.pop_front());
		if (cycles == 95000) begin
			num_errors++;
			print_verdict();
		end
	end

	// h holds last samples: bclk twice back, bclk, sync, d-clock, d-out
	always @(posedge line_clk) begin
		if (meas) begin
			if (bclk_pin & ~h[3]) begin
				if (fsc_pin & ~h[2]) begin
					if (pidx >= 0)
						check(pidx, npulse - 1);
					pidx = 0;
				end else
					pidx++;
				fw += fsc_pin;
			end
			if (~fsc_pin & h[2]) begin
				check(fw == 1 || fw == 2, 1);
				ones += (fw == 1);
				fw = 0;
			end
			if (~bclk_pin & h[3]) begin
				if (hc != half) begin
					odd++;
					check(pidx, want);
					check(hc, half + dir);
				end
				hc = 0;
			end
			hc += bclk_pin;
			if (dchan_port_clock & ~h[1])
				check(h[3] & ~h[4], 1);
		end
		if (arst_n && dchan_serial_out !== h[0])
			check(dchan_port_clock & ~h[1], 1);
		h = {h[3], bclk_pin, fsc_pin, dchan_port_clock, dchan_serial_out};
	end

	// falls counted from reset, as the block counts them, so bytes line up
	always @(negedge dchan_port_clock) begin
		if (arst_n) begin
			dsh = {dsh[6:0], dchan_serial_out};
			dn++;
			if (dchk && dn % 8 == 0)
				check(dsh, dbyte);
		end
	end

	always @(posedge fsync) begin
		fcount++;
		t_fs = $time;
	end
	always @(posedge rx_superframe_marker) mark_rise(0);
	always @(posedge mark_pin) mark_rise(1);
	always @(negedge rx_superframe_marker) mark_fall(0);
	always @(negedge mark_pin) mark_fall(1);
	task automatic mark_rise(input int i);
		if (mmeas) begin
			if (mk_n[i] > 0)
				check(fcount - mk_last[i], `FS_SF_FRAMES);
			if (long_mode)
				check(fsync, 1'b1);
			else
				check($time - t_fs > BIT_NS && $time - t_fs <= 2 * BIT_NS, 1);
			mk_last[i] = fcount;
			mk_n[i]++;
			t_m[i] = $time;
		end
	endtask
	task automatic mark_fall(input int i);
		if (mmeas && mk_n[i] > 0 && !long_mode)
			check($time - t_m[i], BIT_NS);
	endtask

	task automatic master_run(input logic fast, input logic up);
		frame_sync_pkg::ctrl_t c;
		c = '{up, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		half = fast ? `FS_HALF_FAST : `FS_HALF_SLOW;
		npulse = fast ? `FS_PULSES_FAST : `FS_PULSES_SLOW;
		want = fast ? `FS_ADJ_FAST : `FS_ADJ_SLOW;
		dir = up ? 1 : -1;
		@(posedge sys_clk);
		// bit clock stopped while the rate changes: no torn high phase
		wb(1'b1, `FS_ADR_CTRL, 32'(c) & 32'h3d);
		clock_rate_select <= fast;
		wb(1'b1, `FS_ADR_CTRL, 32'(c));
		repeat (2) @(posedge fsc_pin);
		check({bclk_oe, fsc_oe}, 2'b11);
		odd = 0;
		pidx = -1;
		hc = 0;
		fw = 0;
		meas = 1'b1;
		wb(1'b1, `FS_ADR_ADJ, r);
		repeat (3) @(posedge fsc_pin);
		meas = 1'b0;
		check(odd, `FS_ADJ_FRAMES);
	endtask
	task automatic slave_run(input logic lng);
		frame_sync_pkg::ctrl_t c;
		c = '{1'b0, 1'b1, lng, 1'b0, 1'b0, 1'b0};
		@(posedge sys_clk);
		sync_w <= lng ? 2'd2 : 2'd1;
		long_mode = lng;
		wb(1'b1, `FS_ADR_CTRL, 32'(c));
		mk_n = '{0, 0};
		mmeas = 1'b1;
		wait (mk_n[0] > 1 && mk_n[1] > 1);
		mmeas = 1'b0;
		check({bclk_oe, fsc_oe, tx_mark_oe}, 3'b001);
	endtask

	initial begin
		r = $random(seed);
		dbyte = r[7:0];
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(`FS_ADR_CTRL, `FS_CTRL_RST);
		r = $random(seed);
		wb(1'b1, 8'h20, r);
		rd(8'h20, 32'h0);
		wb(1'b1, `FS_ADR_CTRL, r);
		rd(`FS_ADR_CTRL, {26'h0, r[5:0]});
		wb(1'b1, `FS_ADR_DTX, {24'h0, dbyte});
		fork
			begin
				repeat (9) @(negedge dchan_port_clock);
				dchk = 1'b1;
			end
		join_none
		for (int k = 0; k < 4; k++)
			master_run(k[0], k[1]);
		check(ones <= 1, 1);
		slave_run(1'b0);
		slave_run(1'b1);
		rd(`FS_ADR_DRX, {24'h0, dbyte});
		@(posedge sys_clk);
		check(exp_q.size(), 0);
		print_verdict();
	end
endmodule
